//--- hdl/nfi_fifo_irq_status.v
`timescale 1ns/10ps
`include "nfi_fifo_map.vh"

////////////////////////////////////////////////////////////////////////////////
module nfi_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 96,
   parameter CW = 7
) (
   // Clock and reset
   input wire clk_sys,
   input wire sys_rst,
   input wire flush,
   // Fill side
   input wire in_valid,
   output reg in_ready,
   input wire [WIDTH-1:0] in_data,
   // Drain side
   output reg out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data,
   // Occupancy
   output reg [CW-1:0] count_q
);
   localparam [31:0] DEPTH_W = DEPTH;
   localparam [CW-1:0] LAST = DEPTH_W[CW-1:0] - 1'b1;
   localparam [CW-1:0] FULL = DEPTH_W[CW-1:0];
   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [CW-1:0] wr_q;
   reg [CW-1:0] rd_q;
   reg [CW-1:0] count_d;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;

   assign out_data = mem_q[rd_q];

   // One counter serves both sides so a push and pop cancel
   always @*
   begin
      count_d = count_q;
      if (push & ~pop)
         count_d = count_q + 1'b1;
      else if (pop & ~push)
         count_d = count_q - 1'b1;
   end

   // Pointers, flags and counter
   always @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wr_q <= {CW{1'b0}};
         rd_q <= {CW{1'b0}};
         count_q <= {CW{1'b0}};
         in_ready <= 1'b1;
         out_valid <= 1'b0;
      end
      else if (flush)
      begin
         wr_q <= {CW{1'b0}};
         rd_q <= {CW{1'b0}};
         count_q <= {CW{1'b0}};
         in_ready <= 1'b1;
         out_valid <= 1'b0;
      end
      else
      begin
         if (push)
            wr_q <= (wr_q == LAST) ? {CW{1'b0}} : wr_q + 1'b1;
         if (pop)
            rd_q <= (rd_q == LAST) ? {CW{1'b0}} : rd_q + 1'b1;
         count_q <= count_d;
         in_ready <= (count_d != FULL);
         out_valid <= (count_d != {CW{1'b0}});
      end
   end

   // Storage has no reset, only written data is ever read
   always @(posedge clk_sys)
   begin
      if (push)
         mem_q[wr_q] <= in_data;
   end
endmodule // nfi_fifo

////////////////////////////////////////////////////////////////////////////////
module nfi_fifo_irq_status #(
   parameter DEPTH = 96,
   parameter CW = 7,
   parameter [6:0] RX_WL0 = 7'h50,
   parameter [6:0] RX_WL1 = 7'h40,
   parameter [6:0] TX_WL0 = 7'h20,
   parameter [6:0] TX_WL1 = 7'h10
) (
   // Clock and reset
   input wire clk_sys,
   input wire sys_rst,
   // Serial port pins
   input wire spi_ss_n,
   input wire spi_sclk,
   input wire spi_mosi,
   output reg spi_miso,
   output reg spi_miso_oe,
   // Interrupt pin
   output reg irq,
   // Event sources
   input wire [5:0] evt_main,
   input wire [7:0] evt_tmr,
   input wire [7:0] evt_err,
   // Link state
   input wire tx_active,
   input wire tx_frame_loaded,
   input wire rx_start,
   input wire rx_active,
   // Receive store
   input wire rx_valid,
   output wire rx_ready,
   input wire [7:0] rx_data,
   // Receive last-byte status
   input wire rx_last_valid,
   input wire rx_last_incomplete,
   input wire [2:0] last_byte_valid_bits,
   input wire last_byte_parity_missing,
   // Transmit fetch
   input wire tx_req,
   output reg tx_valid,
   output reg [7:0] tx_data
);
   localparam [4:0] S_CMD = 5'h01;
   localparam [4:0] S_WREG = 5'h02;
   localparam [4:0] S_RREG = 5'h04;
   localparam [4:0] S_FLD = 5'h08;
   localparam [4:0] S_FRD = 5'h10;

   // Pin synchronisers, first stage feeds only the second
   reg ss_s1, ss_s2, sck_s1, sck_s2, sck_s3, mosi_s1, mosi_s2;
   always @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ss_s1 <= 1'b1;
         ss_s2 <= 1'b1;
         sck_s1 <= 1'b0;
         sck_s2 <= 1'b0;
         sck_s3 <= 1'b0;
         mosi_s1 <= 1'b0;
         mosi_s2 <= 1'b0;
      end
      else
      begin
         ss_s1 <= spi_ss_n;
         ss_s2 <= ss_s1;
         sck_s1 <= spi_sclk;
         sck_s2 <= sck_s1;
         sck_s3 <= sck_s2;
         mosi_s1 <= spi_mosi;
         mosi_s2 <= mosi_s1;
      end
   end
   wire sck_fall = sck_s3 & ~sck_s2;
   wire sck_rise = ~sck_s3 & sck_s2;

   ////////////////////////////////////////////////////////////////////////////////
   reg [4:0] st_q;
   reg [2:0] bcnt_q;
   reg [7:0] shi_q, sho_q;
   reg [5:0] adr_q;
   reg ld_pend_q;
   reg [7:0] ld_byte_q;
   reg wr_stb_q;
   reg [7:0] wr_byte_q;
   reg [5:0] wr_adr_q;
   reg fr_have_q;
   reg fr_pop_q;
   reg [7:0] cfg_q, mask_main_q, mask_tmr_q, mask_err_q;
   reg [7:0] main_q, tmr_q, err_q, st2_q;
   reg [7:0] rd_val;
   wire [7:0] in_byte = {shi_q[6:0], mosi_s2};
   wire byte_done = ~ss_s2 & sck_fall & (bcnt_q == `NFI_BIT_LAST);
   wire rd_load = ~ss_s2 & sck_rise & (bcnt_q == 3'h0) & (st_q[2] | st_q[4]);
   wire [CW-1:0] count;
   wire f_out_valid;
   wire [7:0] f_out_data;
   wire f_in_ready;
   wire fr_empty = rd_load & st_q[4] & ~f_out_valid;

   assign rx_ready = f_in_ready;

   // Register read multiplexer
   always @*
   begin
      if (adr_q == `NFI_ADR_IO_CFG)
         rd_val = cfg_q;
      else if (adr_q == `NFI_ADR_MASK_MAIN)
         rd_val = mask_main_q;
      else if (adr_q == `NFI_ADR_MASK_TMR)
         rd_val = mask_tmr_q;
      else if (adr_q == `NFI_ADR_MASK_ERR)
         rd_val = mask_err_q;
      else if (adr_q == `NFI_ADR_IRQ_MAIN)
         rd_val = main_q;
      else if (adr_q == `NFI_ADR_IRQ_TMR)
         rd_val = tmr_q;
      else if (adr_q == `NFI_ADR_IRQ_ERR)
         rd_val = err_q;
      else if (adr_q == `NFI_ADR_FSTAT1)
         rd_val = {{(8-CW){1'b0}}, count};
      else if (adr_q == `NFI_ADR_FSTAT2)
         rd_val = st2_q;
      else
         rd_val = 8'h00;
   end

   // Clear strobes fire when a byte is loaded for shifting out
   wire rclr = rd_load & st_q[2];
   wire clr_main = rclr & (adr_q == `NFI_ADR_IRQ_MAIN);
   wire clr_tmr = rclr & (adr_q == `NFI_ADR_IRQ_TMR);
   wire clr_err = rclr & (adr_q == `NFI_ADR_IRQ_ERR);
   wire clr_st2 = rclr & (adr_q == `NFI_ADR_FSTAT2);

   // Serial engine: sample on falling edge, drive on rising edge
   always @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_q <= S_CMD;
         bcnt_q <= 3'h0;
         shi_q <= 8'h00;
         sho_q <= 8'h00;
         adr_q <= 6'h00;
         spi_miso <= 1'b0;
         spi_miso_oe <= 1'b0;
         ld_pend_q <= 1'b0;
         ld_byte_q <= 8'h00;
         wr_stb_q <= 1'b0;
         wr_byte_q <= 8'h00;
         wr_adr_q <= 6'h00;
         fr_have_q <= 1'b0;
         fr_pop_q <= 1'b0;
      end
      else
      begin
         wr_stb_q <= 1'b0;
         fr_pop_q <= 1'b0;
         if (ld_pend_q & ~rx_valid)
            ld_pend_q <= 1'b0;
         if (ss_s2)
         begin
            // Select high: any partial byte is dropped, no pop done
            st_q <= S_CMD;
            bcnt_q <= 3'h0;
            spi_miso_oe <= 1'b0;
            fr_have_q <= 1'b0;
         end
         else
         begin
            if (rd_load)
            begin
               spi_miso <= st_q[4] ? f_out_data[7] & f_out_valid : rd_val[7];
               sho_q <= st_q[4] ? {f_out_data[6:0] & {7{f_out_valid}}, 1'b0} : {rd_val[6:0], 1'b0};
               fr_have_q <= st_q[4] & f_out_valid;
               spi_miso_oe <= 1'b1;
            end
            else if (sck_rise & (st_q[2] | st_q[4]))
            begin
               spi_miso <= sho_q[7];
               sho_q <= {sho_q[6:0], 1'b0};
            end
            if (sck_fall)
            begin
               shi_q <= in_byte;
               bcnt_q <= bcnt_q + 1'b1;
            end
            if (byte_done)
            begin
               case (st_q)
                  S_CMD:
                  begin
                     adr_q <= in_byte[5:0];
                     if (in_byte[7:6] == `NFI_MODE_WR)
                        st_q <= S_WREG;
                     else if (in_byte[7:6] == `NFI_MODE_RD)
                        st_q <= S_RREG;
                     else if (in_byte[7:6] == `NFI_MODE_FIFO && in_byte[5:0] == `NFI_TRL_LOAD)
                        st_q <= S_FLD;
                     else if (in_byte[7:6] == `NFI_MODE_FIFO && in_byte[5:0] == `NFI_TRL_READ)
                        st_q <= S_FRD;
                  end
                  S_WREG:
                  begin
                     wr_stb_q <= 1'b1;
                     wr_byte_q <= in_byte;
                     wr_adr_q <= adr_q;
                     adr_q <= adr_q + 1'b1;
                  end
                  S_RREG:
                     adr_q <= adr_q + 1'b1;
                  S_FLD:
                  begin
                     ld_pend_q <= 1'b1;
                     ld_byte_q <= in_byte;
                  end
                  S_FRD:
                  begin
                     // Pop only after all eight bits left the pin
                     fr_pop_q <= fr_have_q;
                     fr_have_q <= 1'b0;
                  end
                  default:
                     st_q <= S_CMD;
               endcase
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Push and pop arbitration; receive store wins, load waits until rx_valid drops
   reg tx_pend_q;
   wire f_in_valid = rx_valid | ld_pend_q;
   wire [7:0] f_in_data = rx_valid ? rx_data : ld_byte_q;
   wire tx_serve = tx_pend_q & ~fr_pop_q;
   wire f_out_ready = fr_pop_q | (tx_serve & f_out_valid);
   wire ovf_evt = f_in_valid & ~f_in_ready;
   wire unf_evt = fr_empty | (tx_serve & ~f_out_valid);

   // Shared buffer for both directions
   nfi_fifo #(
      .WIDTH(8),
      .DEPTH(DEPTH),
      .CW(CW)
   ) i_nfi_fifo (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .flush(rx_start),
      .in_valid(f_in_valid),
      .in_ready(f_in_ready),
      .in_data(f_in_data),
      .out_valid(f_out_valid),
      .out_ready(f_out_ready),
      .out_data(f_out_data),
      .count_q(count)
   );

   // Transmitter fetch, one byte per request
   always @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         tx_pend_q <= 1'b0;
         tx_valid <= 1'b0;
         tx_data <= 8'h00;
      end
      else
      begin
         tx_valid <= tx_serve & f_out_valid;
         if (tx_serve & f_out_valid)
            tx_data <= f_out_data;
         tx_pend_q <= tx_req | (tx_pend_q & ~tx_serve);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Water-level detection from successive occupancy values
   reg [CW-1:0] cnt_prev_q;
   reg [CW-1:0] wrcnt_q;
   wire [CW-1:0] wl_rx = cfg_q[`NFI_CFG_RXWL] ? RX_WL1 : RX_WL0;
   wire [CW-1:0] wl_tx = cfg_q[`NFI_CFG_TXWL] ? TX_WL1 : TX_WL0;
   wire fmode_busy = ~ss_s2 & (st_q[3] | st_q[4]);
   wire tx_wl = tx_active & ~tx_frame_loaded & (cnt_prev_q == wl_tx + 1'b1) & (count == wl_tx);
   wire tx_low = tx_active & ~tx_frame_loaded & (wrcnt_q < wl_tx) & (cnt_prev_q == `NFI_LOW_LEVEL)
      & (count == `NFI_LOW_LEVEL - 1'b1);
   wire rx_wl = rx_active & (cnt_prev_q == wl_rx - 1'b1) & (count == wl_rx);
   wire wl_evt = ~fmode_busy & (tx_wl | tx_low | rx_wl);
   wire load_push = ld_pend_q & ~rx_valid & f_in_ready;

   // Previous count and bytes loaded in this transmission
   always @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cnt_prev_q <= {CW{1'b0}};
         wrcnt_q <= {CW{1'b0}};
      end
      else
      begin
         cnt_prev_q <= count;
         if (~tx_active)
            wrcnt_q <= {CW{1'b0}};
         else if (load_push & (wrcnt_q != {CW{1'b1}}))
            wrcnt_q <= wrcnt_q + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Flags: set wins over read clear
   reg [5:0] main_src;
   always @*
   begin
      main_src = evt_main;
      main_src[`NFI_SRC_WL] = evt_main[`NFI_SRC_WL] | wl_evt;
   end
   wire [5:0] main_d = (clr_main ? 6'h00 : main_q[`NFI_MAIN_SRC_HI:`NFI_MAIN_SRC_LO]) | main_src;
   wire [7:0] tmr_d = (clr_tmr ? 8'h00 : tmr_q) | evt_tmr;
   wire [7:0] err_d = (clr_err ? 8'h00 : err_q) | evt_err;
   wire ptr_t_d = (clr_tmr ? 1'b0 : main_q[`NFI_MAIN_PTR_TMR]) | (|evt_tmr);
   wire ptr_e_d = (clr_err ? 1'b0 : main_q[`NFI_MAIN_PTR_ERR]) | (|evt_err);
   // Masked flags still latch, only the pin ignores them
   wire irq_d = (|(main_d & ~mask_main_q[`NFI_MAIN_SRC_HI:`NFI_MAIN_SRC_LO]))
      | (|(tmr_d & ~mask_tmr_q)) | (|(err_d & ~mask_err_q));

   always @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         main_q <= `NFI_REG_RST;
         tmr_q <= `NFI_REG_RST;
         err_q <= `NFI_REG_RST;
         irq <= 1'b0;
      end
      else
      begin
         main_q <= {main_d, ptr_t_d, ptr_e_d};
         tmr_q <= tmr_d;
         err_q <= err_d;
         irq <= irq_d;
      end
   end

   // Writable registers; flag and status addresses ignore writes
   always @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cfg_q <= `NFI_REG_RST;
         mask_main_q <= `NFI_REG_RST;
         mask_tmr_q <= `NFI_REG_RST;
         mask_err_q <= `NFI_REG_RST;
      end
      else if (wr_stb_q)
      begin
         if (wr_adr_q == `NFI_ADR_IO_CFG)
            cfg_q <= wr_byte_q;
         else if (wr_adr_q == `NFI_ADR_MASK_MAIN)
            mask_main_q <= wr_byte_q;
         else if (wr_adr_q == `NFI_ADR_MASK_TMR)
            mask_tmr_q <= wr_byte_q;
         else if (wr_adr_q == `NFI_ADR_MASK_ERR)
            mask_err_q <= wr_byte_q;
      end
   end

   // Second status: error flags and last-byte info, cleared by read or reception start
   always @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         st2_q <= `NFI_REG_RST;
      else
      begin
         if (clr_st2 | rx_start)
            st2_q <= `NFI_REG_RST;
         if (ovf_evt)
            st2_q[`NFI_ST2_OVF] <= 1'b1;
         if (unf_evt)
            st2_q[`NFI_ST2_UNF] <= 1'b1;
         if (rx_last_valid)
         begin
            st2_q[`NFI_ST2_NCP] <= rx_last_incomplete;
            st2_q[`NFI_ST2_LB_HI:`NFI_ST2_LB_LO] <= last_byte_valid_bits;
            st2_q[`NFI_ST2_NP] <= last_byte_parity_missing;
         end
      end
   end
endmodule // nfi_fifo_irq_status

//--- hdl/nfi_fifo_map.vh
`ifndef NFI_FIFO_MAP_VH
`define NFI_FIFO_MAP_VH
// Register addresses on the serial port
`define NFI_ADR_IO_CFG 6'h01
`define NFI_ADR_MASK_MAIN 6'h14
`define NFI_ADR_MASK_TMR 6'h15
`define NFI_ADR_MASK_ERR 6'h16
`define NFI_ADR_IRQ_MAIN 6'h17
`define NFI_ADR_IRQ_TMR 6'h18
`define NFI_ADR_IRQ_ERR 6'h19
`define NFI_ADR_FSTAT1 6'h1A
`define NFI_ADR_FSTAT2 6'h1B
// Mode bits of the first byte and FIFO trailers
`define NFI_MODE_WR 2'h0
`define NFI_MODE_RD 2'h1
`define NFI_MODE_FIFO 2'h2
`define NFI_MODE_DCMD 2'h3
`define NFI_TRL_LOAD 6'h00
`define NFI_TRL_READ 6'h3F
// Configuration bits
`define NFI_CFG_RXWL 7
`define NFI_CFG_TXWL 6
// Main flag layout: sources in 7:2, pointers in 1:0
`define NFI_MAIN_SRC_HI 7
`define NFI_MAIN_SRC_LO 2
`define NFI_MAIN_PTR_TMR 1
`define NFI_MAIN_PTR_ERR 0
`define NFI_SRC_WL 4
// Second FIFO status layout, bit 4 reads zero
`define NFI_ST2_OVF 7
`define NFI_ST2_UNF 6
`define NFI_ST2_NCP 5
`define NFI_ST2_LB_HI 3
`define NFI_ST2_LB_LO 1
`define NFI_ST2_NP 0
// Reset values and counts
`define NFI_REG_RST 8'h00
`define NFI_LOW_LEVEL 7'h04
`define NFI_BIT_LAST 3'h7
`endif

//--- dv/nfi_spi_host.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module nfi_spi_host (
   // Serial pins
   output logic ss_n,
   output logic sclk,
   output logic mosi,
   input wire logic miso,
   input wire logic oe
);
   // Idle: select high, clock low
   initial
   begin
      ss_n = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end

   // Select, then settle before the first edge
   task automatic sel();
      #3 ss_n = 1'b0;
      #100;
   endtask

   // Release 300 ns after the transfer; data flips so a stale bit never looks valid
   task automatic desel();
      #300 ss_n = 1'b1;
      mosi = ~mosi;
      #200;
   endtask

   // Mode 1, MSB first, 160 ns period, well above twice any link bit rate
   task automatic xb(input logic [7:0] t, input int n, output logic [7:0] r);
      r = 8'h00;
      for (int i = 7; i > 7 - n; i--)
      begin
         // Data moves only well after the falling edge, so the sampled bit holds
         #20 mosi = t[i];
         #60 sclk = 1'b1;
         #80 r[i] = oe ? miso : ~miso;
         sclk = 1'b0;
      end
   endtask
endmodule // nfi_spi_host

//--- dv/nfi_fifo_irq_status_monitor.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module nfi_fifo_irq_status_monitor (
   // Clock and reset
   input wire clk_sys,
   input wire sys_rst,
   // Serial pins
   input wire spi_ss_n,
   input wire spi_sclk,
   input wire spi_miso,
   input wire spi_miso_oe,
   input wire irq,
   // Data path
   input wire rx_start,
   input wire rx_valid,
   input wire rx_ready,
   input wire tx_req,
   input wire tx_valid
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   // Select high long enough to pass the synchroniser
   sequence sel_idle;
      spi_ss_n [*7];
   endsequence
   // A transmit fetch one or two cycles back
   sequence tx_asked;
      $past(tx_req) || $past(tx_req, 2);
   endsequence

   chk_oe_idle_off: assert property (sel_idle |-> !spi_miso_oe)
      else $error("miso driven while deselected");
   chk_oe_rise_sel: assert property ($rose(spi_miso_oe) |-> !spi_ss_n)
      else $error("miso enabled outside a frame");
   chk_miso_on_rise: assert property ($changed(spi_miso) && spi_miso_oe && $past(spi_miso_oe) |-> $past(spi_sclk, 2))
      else $error("miso moved away from a rising clock");
   chk_irq_fall_read: assert property ($fell(irq) |-> !spi_ss_n)
      else $error("irq dropped without a read");
   chk_tx_answer: assert property (tx_valid |-> tx_asked)
      else $error("tx byte without request");
   chk_flush_ready: assert property (rx_start |-> ##[1:2] rx_ready)
      else $error("fifo not emptied at reception start");
   chk_ready_fall: assert property ($fell(rx_ready) |-> $past(rx_valid) || $past(rx_valid, 2) || !spi_ss_n)
      else $error("fifo filled without a push");
   chk_ready_rise: assert property ($rose(rx_ready) |-> tx_asked or ($past(rx_start) || !spi_ss_n))
      else $error("fifo space without a pop");
endmodule // nfi_fifo_irq_status_monitor

bind nfi_fifo_irq_status nfi_fifo_irq_status_monitor i_nfi_fifo_irq_status_monitor (.clk_sys(clk_sys),
   .sys_rst(sys_rst), .spi_ss_n(spi_ss_n), .spi_sclk(spi_sclk), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
   .irq(irq), .rx_start(rx_start), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_req(tx_req), .tx_valid(tx_valid));

//--- dv/nfi_fifo_irq_status_tb_top.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module nfi_fifo_irq_status_tb_top;
   logic clk_sys, sys_rst, spi_ss_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe, irq;
   logic [5:0] evt_main;
   logic [7:0] evt_tmr, evt_err, rx_data, tx_data;
   logic tx_active, tx_frame_loaded, rx_start, rx_active, rx_valid, rx_ready, tx_req, tx_valid;
   logic rx_last_valid, rx_last_incomplete, last_byte_parity_missing;
   logic [2:0] last_byte_valid_bits;
   logic [7:0] rb [8];
   int failures, n_compared, cyc;

   // Small water levels keep the run short
   nfi_fifo_irq_status #(.RX_WL0(7'h06), .RX_WL1(7'h04), .TX_WL0(7'h05), .TX_WL1(7'h03)) i_nfi_fifo_irq_status (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .spi_ss_n(spi_ss_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
      .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .irq(irq), .evt_main(evt_main), .evt_tmr(evt_tmr),
      .evt_err(evt_err), .tx_active(tx_active), .tx_frame_loaded(tx_frame_loaded), .rx_start(rx_start),
      .rx_active(rx_active), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
      .rx_last_valid(rx_last_valid), .rx_last_incomplete(rx_last_incomplete),
      .last_byte_valid_bits(last_byte_valid_bits), .last_byte_parity_missing(last_byte_parity_missing),
      .tx_req(tx_req), .tx_valid(tx_valid), .tx_data(tx_data));
   nfi_spi_host i_nfi_spi_host (.ss_n(spi_ss_n), .sclk(spi_sclk), .mosi(spi_mosi), .miso(spi_miso),
      .oe(spi_miso_oe));

   // Clock and hang guard
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         failures++;
         complete_run();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      if (failures == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One select frame: command, n data bytes, then tail loose bits
   task automatic frame(input logic [7:0] cmd, input int n, input logic [7:0] wd, input int tail);
      logic [7:0] r;
      i_nfi_spi_host.sel();
      i_nfi_spi_host.xb(cmd, 8, r);
      for (int k = 0; k < n; k++)
      begin
         i_nfi_spi_host.xb(wd + 8'(k), 8, r);
         rb[k] = r;
      end
      if (tail > 0)
         i_nfi_spi_host.xb(8'hFF, tail, r);
      i_nfi_spi_host.desel();
      repeat (4) @(negedge clk_sys);
   endtask

   task automatic pulse(input logic [5:0] m, input logic [7:0] t, input logic [7:0] e);
      @(negedge clk_sys);
      evt_main = m;
      evt_tmr = t;
      evt_err = e;
      @(negedge clk_sys);
      evt_main = 6'h00;
      evt_tmr = 8'h00;
      evt_err = 8'h00;
      repeat (2) @(negedge clk_sys);
   endtask

   // Back-to-back receive stores, one a cycle
   task automatic push(input int n, input logic [7:0] base);
      for (int k = 0; k < n; k++)
      begin
         @(negedge clk_sys);
         rx_valid = 1'b1;
         rx_data = base + 8'(k);
      end
      @(negedge clk_sys);
      rx_valid = 1'b0;
      repeat (3) @(negedge clk_sys);
   endtask

   task automatic pop(input logic [7:0] exp, input logic ok);
      logic got;
      logic [7:0] d;
      got = 1'b0;
      d = 8'h00;
      @(negedge clk_sys);
      tx_req = 1'b1;
      repeat (3)
      begin
         @(negedge clk_sys);
         tx_req = 1'b0;
         if (tx_valid === 1'b1)
         begin
            got = 1'b1;
            d = tx_data;
         end
      end
      chk({7'h00, got}, {7'h00, ok});
      if (ok)
         chk(d, exp);
   endtask

   task automatic rx_begin();
      @(negedge clk_sys);
      rx_start = 1'b1;
      @(negedge clk_sys);
      rx_start = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_values();
      frame(8'h57, 3, 8'h00, 0);
      for (int k = 0; k < 3; k++)
         chk(rb[k], 8'h00);
      frame(8'h1A, 1, 8'hFF, 0);
      frame(8'h5A, 2, 8'h00, 0);
      chk(rb[0], 8'h00);
      chk(rb[1], 8'h00);
      frame(8'h7E, 1, 8'h00, 0);
      chk(rb[0], 8'h00);
      chk({6'h00, irq, rx_ready}, 8'h01);
   endtask

   // Pointer bits, pending flags, masking
   task automatic t_irq();
      pulse(6'h01, 8'h08, 8'h00);
      chk({7'h00, irq}, 8'h01);
      frame(8'h57, 1, 8'h00, 0);
      chk(rb[0], 8'h06);
      chk({7'h00, irq}, 8'h01);
      frame(8'h57, 3, 8'h00, 0);
      chk(rb[0], 8'h02);
      chk(rb[1], 8'h08);
      chk(rb[2], 8'h00);
      chk({7'h00, irq}, 8'h00);
      frame(8'h16, 1, 8'h01, 0);
      pulse(6'h00, 8'h00, 8'h01);
      chk({7'h00, irq}, 8'h00);
      frame(8'h59, 1, 8'h00, 0);
      chk(rb[0], 8'h01);
      frame(8'h57, 1, 8'h00, 0);
      chk(rb[0], 8'h00);
      frame(8'h16, 1, 8'h00, 0);
   endtask

   // Receive: level, overflow, partial read, status 2, flush, suppression
   task automatic t_rx();
      frame(8'h01, 1, 8'h80, 0);
      // Direct command byte is skipped, the next byte opens a read
      frame(8'hC2, 2, 8'h41, 0);
      chk(rb[1], 8'h80);
      rx_active = 1'b1;
      rx_begin();
      push(3, 8'h10);
      chk({7'h00, irq}, 8'h00);
      push(1, 8'h13);
      chk({7'h00, irq}, 8'h01);
      frame(8'h57, 1, 8'h00, 0);
      chk(rb[0], 8'h40);
      push(93, 8'h14);
      chk({7'h00, rx_ready}, 8'h00);
      frame(8'hBF, 0, 8'h00, 4);
      frame(8'hBF, 2, 8'h00, 0);
      chk(rb[0], 8'h10);
      chk(rb[1], 8'h11);
      @(negedge clk_sys);
      rx_last_valid = 1'b1;
      rx_last_incomplete = 1'b1;
      last_byte_valid_bits = 3'h5;
      last_byte_parity_missing = 1'b1;
      @(negedge clk_sys);
      rx_last_valid = 1'b0;
      frame(8'h5A, 2, 8'h00, 0);
      chk(rb[0], 8'h5E);
      chk(rb[1], 8'hAB);
      frame(8'h5B, 1, 8'h00, 0);
      chk(rb[0] & 8'h2F, 8'h00);
      rx_begin();
      frame(8'h5A, 2, 8'h00, 0);
      chk(rb[0], 8'h00);
      chk(rb[1], 8'h00);
      fork
         frame(8'hBF, 0, 8'h00, 0);
         begin
            repeat (141) @(negedge clk_sys);
            push(5, 8'h30);
         end
      join
      chk({7'h00, irq}, 8'h00);
      rx_active = 1'b0;
      rx_begin();
   endtask

   // Transmit: short load, level crossing, dropped half byte, underflow
   task automatic t_tx();
      frame(8'h01, 1, 8'h00, 0);
      tx_active = 1'b1;
      frame(8'h80, 4, 8'hA0, 0);
      pop(8'hA0, 1'b1);
      chk({7'h00, irq}, 8'h01);
      frame(8'h57, 1, 8'h00, 0);
      chk(rb[0], 8'h40);
      frame(8'h80, 6, 8'hA4, 4);
      frame(8'h5A, 1, 8'h00, 0);
      chk(rb[0], 8'h09);
      for (int k = 1; k < 10; k++)
      begin
         pop(8'hA0 + 8'(k), 1'b1);
         chk({7'h00, irq}, {7'h00, k >= 4});
      end
      pop(8'h00, 1'b0);
      frame(8'h5B, 1, 8'h00, 0);
      chk(rb[0], 8'h40);
      frame(8'h57, 1, 8'h00, 0);
      chk(rb[0], 8'h40);
      // Whole frame loaded: the same crossing must stay quiet
      tx_frame_loaded = 1'b1;
      frame(8'h80, 6, 8'hB0, 0);
      pop(8'hB0, 1'b1);
      chk({7'h00, irq}, 8'h00);
      tx_frame_loaded = 1'b0;
      tx_active = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk_sys = 1'b0;
      sys_rst = 1'b1;
      {evt_main, evt_tmr, evt_err, rx_data} = '0;
      {tx_active, tx_frame_loaded, rx_start, rx_active, rx_valid, tx_req} = '0;
      {rx_last_valid, rx_last_incomplete, last_byte_valid_bits, last_byte_parity_missing} = '0;
      failures = 0;
      n_compared = 0;
      cyc = 0;
      repeat (4) @(negedge clk_sys);
      sys_rst = 1'b0;
      repeat (4) @(negedge clk_sys);
      t_reset_values();
      t_irq();
      t_rx();
      t_tx();
      complete_run();
   end
endmodule // nfi_fifo_irq_status_tb_top
